// file: hw/port_pad_config_decoder.sv
// eight-pin port with pad configuration, direction and data registers on AXI4-Lite
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "port_pad_defines.svh"
module port_pad_config_decoder
   import port_pad_pkg::*;
(
   // clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   // axi4-lite write address and data
   input  wire logic [17:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // axi4-lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [17:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // pads
   input  wire logic [7:0]  padIn,
   output logic      [7:0]  padOut,
   output logic      [7:0]  padOe,
   output logic      [7:0]  pullUpEn,
   output logic      [7:0]  pullDownEn
);
   import port_pad_pkg::*;

   logic [15:0] portPadConfig_r, portPadConfig_nxt;
   logic [7:0]  portDirection_r, portDirection_nxt;
   logic [7:0]  portOutputValue_r, portOutputValue_nxt;
   logic        awHeld_r, awHeld_nxt;
   logic        wHeld_r, wHeld_nxt;
   logic [17:0] awAddr_r, awAddr_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0]  wStrb_r, wStrb_nxt;
   bus_state_t  wrState_r, wrState_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   bus_state_t  rdState_r, rdState_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  rresp_r, rresp_nxt;
   logic        doWrite;
   logic [7:0]  pinLevel;

   assign awready = clkEn && (wrState_r == BUS_IDLE) && !awHeld_r;
   assign wready  = clkEn && (wrState_r == BUS_IDLE) && !wHeld_r;
   assign arready = clkEn && (rdState_r == BUS_IDLE);
   assign bvalid  = (wrState_r == BUS_RESP);
   assign rvalid  = (rdState_r == BUS_RESP);
   assign bresp   = bresp_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;
   assign doWrite = awHeld_r && wHeld_r && (wrState_r == BUS_IDLE);

   // write channel: address and data taken in either order, then applied
   always_comb
   begin
      awHeld_nxt          = awHeld_r;
      wHeld_nxt           = wHeld_r;
      awAddr_nxt          = awAddr_r;
      wData_nxt           = wData_r;
      wStrb_nxt           = wStrb_r;
      wrState_nxt         = wrState_r;
      bresp_nxt           = bresp_r;
      portPadConfig_nxt   = portPadConfig_r;
      portDirection_nxt   = portDirection_r;
      portOutputValue_nxt = portOutputValue_r;
      if (awvalid && awready)
      begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = awaddr;
      end
      if (wvalid && wready)
      begin
         wHeld_nxt = 1'b1;
         wData_nxt = wdata;
         wStrb_nxt = wstrb;
      end
      if (doWrite)
      begin
         awHeld_nxt  = 1'b0;
         wHeld_nxt   = 1'b0;
         wrState_nxt = BUS_RESP;
         bresp_nxt   = `AXI_RESP_OKAY;
         if (awAddr_r[17:2] == `ADDR_PAD_CONFIG)
         begin
            // each lane updates its own half only
            if (wStrb_r[0])
               portPadConfig_nxt[15:8] = wData_r[15:8];
            if (wStrb_r[0])
               portPadConfig_nxt[7:0] = wData_r[7:0];
            if (wStrb_r[1])
               portPadConfig_nxt[15:8] = wData_r[15:8];
            if (!wStrb_r[0])
               portPadConfig_nxt[15:8] = wStrb_r[1] ? wData_r[15:8] : portPadConfig_r[15:8];
            if (wStrb_r[0] && !wStrb_r[1])
               portPadConfig_nxt[15:8] = portPadConfig_r[15:8];
         end
         else if (awAddr_r[17:2] == `ADDR_PORT_DIR)
         begin
            if (wStrb_r[0])
               portDirection_nxt = wData_r[7:0];
         end
         else if (awAddr_r[17:2] == `ADDR_PORT_DATA)
         begin
            if (wStrb_r[0])
               portOutputValue_nxt = wData_r[7:0];
         end
         else
            bresp_nxt = `AXI_RESP_SLVERR;
      end
      else if ((wrState_r == BUS_RESP) && bready)
         wrState_nxt = BUS_IDLE;
   end

   // pins read back their own level in input mode, the latch in output mode
   assign pinLevel = (portDirection_r & padIn) | (~portDirection_r & portOutputValue_r);

   // read channel: one cycle to answer
   always_comb
   begin
      rdState_nxt = rdState_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (arvalid && arready)
      begin
         rdState_nxt = BUS_RESP;
         rresp_nxt   = `AXI_RESP_OKAY;
         if (araddr[17:2] == `ADDR_PAD_CONFIG)
            rdata_nxt = {16'h0000, portPadConfig_r};
         else if (araddr[17:2] == `ADDR_PORT_DIR)
            rdata_nxt = {24'h000000, portDirection_r};
         else if (araddr[17:2] == `ADDR_PORT_DATA)
            rdata_nxt = {24'h000000, pinLevel};
         else
         begin
            rdata_nxt = 32'h00000000;
            rresp_nxt = `AXI_RESP_SLVERR;
         end
      end
      else if ((rdState_r == BUS_RESP) && rready)
         rdState_nxt = BUS_IDLE;
   end

   // registers; clock enable low freezes everything but reset
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         portPadConfig_r   <= `RESET_PAD_CONFIG;
         portDirection_r   <= `RESET_PORT_DIR;
         portOutputValue_r <= `RESET_PORT_DATA;
         awHeld_r          <= 1'b0;
         wHeld_r           <= 1'b0;
         awAddr_r          <= 18'h00000;
         wData_r           <= 32'h00000000;
         wStrb_r           <= 4'h0;
         wrState_r         <= BUS_IDLE;
         bresp_r           <= 2'h0;
         rdState_r         <= BUS_IDLE;
         rdata_r           <= 32'h00000000;
         rresp_r           <= 2'h0;
      end
      else if (clkEn)
      begin
         portPadConfig_r   <= portPadConfig_nxt;
         portDirection_r   <= portDirection_nxt;
         portOutputValue_r <= portOutputValue_nxt;
         awHeld_r          <= awHeld_nxt;
         wHeld_r           <= wHeld_nxt;
         awAddr_r          <= awAddr_nxt;
         wData_r           <= wData_nxt;
         wStrb_r           <= wStrb_nxt;
         wrState_r         <= wrState_nxt;
         bresp_r           <= bresp_nxt;
         rdState_r         <= rdState_nxt;
         rdata_r           <= rdata_nxt;
         rresp_r           <= rresp_nxt;
      end
   end

   // one decoder per pin; code bits at matching positions of each byte
   genvar gi;
   generate
      for (gi = 0; gi < `PIN_COUNT; gi++)
      begin : g_pin
         pad_cell_decode u_cell
         (
            .padCode0        (portPadConfig_r[`CFG_LOW_LSB + gi]),
            .padCode1        (portPadConfig_r[`CFG_HIGH_LSB + gi]),
            .pinDirectionBit (portDirection_r[gi]),
            .portOutputValue (portOutputValue_r[gi]),
            .padOut          (padOut[gi]),
            .padOe           (padOe[gi]),
            .pullUpEn        (pullUpEn[gi]),
            .pullDownEn      (pullDownEn[gi])
         );
      end
   endgenerate

   // byte-lane writes touch only their half
   a_cfg_low_only: assert property (@(posedge mclk) disable iff (!rst_n)
      (clkEn && doWrite && awAddr_r[17:2] == `ADDR_PAD_CONFIG && wStrb_r[1:0] == 2'b01)
      |=> (portPadConfig_r[15:8] == $past(portPadConfig_r[15:8])))
      else $error("high half changed on low byte write");
   a_cfg_both: assert property (@(posedge mclk) disable iff (!rst_n)
      (clkEn && doWrite && awAddr_r[17:2] == `ADDR_PAD_CONFIG && wStrb_r[1:0] == 2'b11)
      |=> (portPadConfig_r == $past(wData_r[15:0])))
      else $error("16-bit write not applied");
   a_reset_zero: assert property (@(posedge mclk)
      $rose(rst_n) |-> (portPadConfig_r == 16'h0000 && portDirection_r == 8'h00))
      else $error("registers not zero after reset");
   a_hiz_code: assert property (@(posedge mclk) disable iff (!rst_n)
      (!portDirection_r[0] && portPadConfig_r[8] == 1'b0 && portPadConfig_r[0] == 1'b0)
      |-> !padOe[0])
      else $error("code 00 drives pin");
   a_pch_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      (!portDirection_r[1] && {portPadConfig_r[9], portPadConfig_r[1]} == 2'h1)
      |-> (padOe[1] == portOutputValue_r[1] && padOut[1]))
      else $error("p-channel drive wrong");
   a_nch_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      (!portDirection_r[2] && {portPadConfig_r[10], portPadConfig_r[2]} == 2'h2)
      |-> (padOe[2] == !portOutputValue_r[2] && !padOut[2]))
      else $error("n-channel drive wrong");
   a_cmos_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      (!portDirection_r[3] && {portPadConfig_r[11], portPadConfig_r[3]} == 2'h3)
      |-> (padOe[3] && padOut[3] == portOutputValue_r[3] && !pullUpEn[3]))
      else $error("cmos drive wrong");
   a_input_pulls: assert property (@(posedge mclk) disable iff (!rst_n)
      portDirection_r[4] |-> (!padOe[4]
      && pullDownEn[4] == ({portPadConfig_r[12], portPadConfig_r[4]} == 2'h1)
      && pullUpEn[4] == ({portPadConfig_r[12], portPadConfig_r[4]} == 2'h2)))
      else $error("input termination wrong");
   a_dir_write: assert property (@(posedge mclk) disable iff (!rst_n)
      (clkEn && doWrite && awAddr_r[17:2] == `ADDR_PORT_DIR && wStrb_r[0])
      |=> (portDirection_r == $past(wData_r[7:0])))
      else $error("direction write lost");
endmodule

// file: hw/port_pad_defines.svh
// register offsets, field positions and reset values of the pad-configuration port
`ifndef PORT_PAD_DEFINES_SVH
`define PORT_PAD_DEFINES_SVH
`define PIN_COUNT            8
`define ADDR_PORT_DATA       16'hf228
`define ADDR_PORT_DIR        16'hf229
`define ADDR_PAD_CONFIG      16'hf22a
// byte addresses: each register is one word, four times its index above
`define WORD_DATA            18'h3c8a0
`define WORD_DIR             18'h3c8a4
`define WORD_CONFIG          18'h3c8a8
`define RESET_PAD_CONFIG     16'h0000
`define RESET_PORT_DIR       8'h00
`define RESET_PORT_DATA      8'h00
`define CFG_LOW_LSB          0
`define CFG_HIGH_LSB         8
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2
`endif

// file: hw/port_pad_pkg.sv
// types shared by the pad-configuration port
package port_pad_pkg;
   typedef enum logic [1:0]
   {
      CODE_HIZ  = 2'h0,
      CODE_PCH  = 2'h1,
      CODE_NCH  = 2'h2,
      CODE_CMOS = 2'h3
   } pad_code_t;
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'h0,
      BUS_RESP = 2'h1
   } bus_state_t;
endpackage

// file: hw/pad_cell_decode.sv
// per-pin decode of configuration code and direction into driver and pull controls
`timescale 1ns/1ps
module pad_cell_decode
   import port_pad_pkg::*;
(
   // configuration of one pin
   input  wire logic      padCode0,
   input  wire logic      padCode1,
   input  wire logic      pinDirectionBit,
   input  wire logic      portOutputValue,
   // pad controls
   output logic           padOut,
   output logic           padOe,
   output logic           pullUpEn,
   output logic           pullDownEn
);
   pad_code_t code;
   assign code = pad_code_t'({padCode1, padCode0});

   // output mode drives per code, input mode only picks terminations
   always_comb
   begin
      padOut     = 1'b0;
      padOe      = 1'b0;
      pullUpEn   = 1'b0;
      pullDownEn = 1'b0;
      if (!pinDirectionBit)
      begin
         case (code)
            CODE_HIZ:  padOe = 1'b0;
            CODE_PCH:
            begin
               padOut = 1'b1;
               padOe  = portOutputValue;
            end
            CODE_NCH:
            begin
               padOut = 1'b0;
               padOe  = !portOutputValue;
            end
            default:
            begin
               padOut = portOutputValue;
               padOe  = 1'b1;
            end
         endcase
      end
      else
      begin
         // codes 00 and 11 leave the input floating
         pullDownEn = (code == CODE_PCH);
         pullUpEn   = (code == CODE_NCH);
      end
   end
endmodule

// file: verif/tb_port_pad_config_decoder.sv
// self-checking bench for the pad-configuration port over axi4-lite
`timescale 1ns/1ps
`include "port_pad_defines.svh"
`define CHECK_EQ(what, exp, got) begin checks++; if ((got) !== (exp)) begin nErrors++; \
   $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module tb_port_pad_config_decoder;
   import port_pad_pkg::*;
   logic        mclk;
   logic        rst_n;
   logic        clkEn;
   logic [17:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [17:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic [7:0]  padIn;
   logic [7:0]  padOut;
   logic [7:0]  padOe;
   logic [7:0]  pullUpEn;
   logic [7:0]  pullDownEn;
   int          nErrors;
   int          checks;
   int          cycles;
   logic [31:0] rd;
   logic [1:0]  rs;
   logic [7:0]  dirs [3] = '{8'h00, 8'hff, 8'h0f};
   logic [7:0]  dats [2] = '{8'h5a, 8'ha5};
   port_pad_config_decoder u_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .padIn(padIn), .padOut(padOut), .padOe(padOe),
      .pullUpEn(pullUpEn), .pullDownEn(pullDownEn));
   // 25 mhz clock
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // hang guard, far above the hundred-odd cycles the tests need
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         nErrors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks, nErrors);
      if (nErrors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // handshakes judged mid-cycle, releases made just after the taking edge;
   // each call starts one edge later so a release is never overwritten in its own step
   task automatic axiWrite(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
      logic tAw, tW, tB;
      @(posedge mclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      tB = 1'b0;
      while (!tB)
      begin
         @(negedge mclk);
         tAw = awvalid && awready;
         tW  = wvalid && wready;
         tB  = bvalid && bready;
         r   = bresp;
         @(posedge mclk);
         if (tAw) awvalid <= 1'b0;
         if (tW) wvalid <= 1'b0;
         if (tB) bready <= 1'b0;
      end
   endtask
   task automatic axiRead(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
      logic tAr, tR;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      tR = 1'b0;
      while (!tR)
      begin
         @(negedge mclk);
         tAr = arvalid && arready;
         tR  = rvalid && rready;
         d   = rdata;
         r   = rresp;
         @(posedge mclk);
         if (tAr) arvalid <= 1'b0;
         if (tR) rready <= 1'b0;
      end
   endtask
   // a mapped write must be answered okay
   task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axiWrite(a, d, s, r);
      `CHECK_EQ("write response", `AXI_RESP_OKAY, r)
   endtask
   // read and compare data and an okay response
   task automatic rdChk(input logic [17:0] a, input logic [31:0] e);
      axiRead(a, rd, rs);
      `CHECK_EQ("read data", e, rd)
      `CHECK_EQ("read response", `AXI_RESP_OKAY, rs)
   endtask
   // expected {pull-up, pull-down, enable, driven level} for all pins
   function automatic logic [31:0] padExp(input logic [15:0] cfg, input logic [7:0] dir,
                                          input logic [7:0] dat);
      logic [7:0] o, oe, pu, pd;
      logic [1:0] c;
      {o, oe, pu, pd} = '0;
      for (int i = 0; i < 8; i++)
      begin
         c = {cfg[i+8], cfg[i]};
         if (dir[i])
         begin
            pd[i] = (c == CODE_PCH);
            pu[i] = (c == CODE_NCH);
         end
         else
         begin
            oe[i] = (c == CODE_CMOS) || (c == CODE_PCH ? dat[i] : c == CODE_NCH && !dat[i]);
            o[i]  = (c == CODE_PCH || c == CODE_CMOS) && dat[i];
         end
      end
      return {pu, pd, oe, o};
   endfunction
   task automatic padChk(input logic [15:0] cfg, input logic [7:0] dir, input logic [7:0] dat);
      #1;
      `CHECK_EQ("pads", padExp(cfg, dir, dat), {pullUpEn, pullDownEn, padOe, padOut & padOe})
   endtask
   // main sequence
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
      {nErrors, checks, cycles} = '0;
      clkEn = 1'b1;
      padIn = 8'h96;
      rst_n = 1'b0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rdChk(`WORD_CONFIG, 32'h0);
      rdChk(`WORD_DIR, 32'h0);
      rdChk(`WORD_DATA, 32'h0);
      padChk(16'h0000, 8'h00, 8'h00);
      // byte lanes: junk in the other lane must not land
      wr(`WORD_CONFIG, 32'hffff55aa, 4'h1);
      rdChk(`WORD_CONFIG, 32'h00aa);
      wr(`WORD_CONFIG, 32'h0000cc11, 4'h2);
      rdChk(`WORD_CONFIG, 32'hccaa);
      // pins 0..7 carry codes 00,01,10,11 twice over
      foreach (dirs[i])
         foreach (dats[j])
         begin
            wr(`WORD_DIR, {24'h0, dirs[i]}, 4'h1);
            wr(`WORD_DATA, {24'h0, dats[j]}, 4'h1);
            padChk(16'hccaa, dirs[i], dats[j]);
            rdChk(`WORD_DATA, (padIn & dirs[i]) | (dats[j] & ~dirs[i]));
         end
      // unmapped word: error, nothing stored, zero read back
      axiWrite(18'h3c8b0, 32'hffff, 4'hf, rs);
      `CHECK_EQ("unmapped write response", `AXI_RESP_SLVERR, rs)
      axiRead(18'h3c8b0, rd, rs);
      `CHECK_EQ("unmapped read data", 32'h0, rd)
      `CHECK_EQ("unmapped read response", `AXI_RESP_SLVERR, rs)
      rdChk(`WORD_CONFIG, 32'hccaa);
      // both halves in one write
      wr(`WORD_CONFIG, 32'h000033cc, 4'h3);
      rdChk(`WORD_CONFIG, 32'h33cc);
      // upper four pins stay outputs, pin 4 sinks through n-channel
      padChk(16'h33cc, 8'h0f, 8'ha5);
      // frozen clock enable: no channel ready, stored value kept
      @(posedge mclk);
      clkEn <= 1'b0;
      @(negedge mclk);
      `CHECK_EQ("ready while frozen", 3'h0, {awready, wready, arready})
      @(posedge mclk);
      clkEn <= 1'b1;
      rdChk(`WORD_CONFIG, 32'h33cc);
      tally_and_finish();
   end
endmodule
